// file: core/nclk_defs.vh
// Purpose: Register offsets, field positions, reset values and timing for the NVM command front end
// Assumes: Included by bare name from core design files
// Notes: Definitions only
`ifndef NCLK_DEFS_VH
`define NCLK_DEFS_VH

// Register offsets (3-bit address)
`define NCLK_ADDR_W 3
`define NCLK_OFF_CLKDIV 3'h0
`define NCLK_OFF_STATUS 3'h1
`define NCLK_OFF_INDEX 3'h2
`define NCLK_OFF_PARAM 3'h3
`define NCLK_OFF_CONFIG 3'h4
`define NCLK_OFF_ECCSTAT 3'h5
`define NCLK_OFF_ECCCFG 3'h6
`define NCLK_OFF_SECURE 3'h7

// Clock divider register fields
`define NCLK_DIV_LOADED_BIT 7
`define NCLK_DIV_RESET 6'h00

// Status register fields
`define NCLK_ST_CCF_BIT 7
`define NCLK_ST_ACC_BIT 5
`define NCLK_ST_PV_BIT 4

// Config / ECC fields
`define NCLK_CFG_COMPLETE_IRQ_ENABLE_BIT 7
`define NCLK_ECC_DF_BIT 1
`define NCLK_ECC_SF_BIT 0

// Parameter array
`define NCLK_PARAM_WORDS 6
`define NCLK_IDX_CMD 3'h0

// Command codes
`define NCLK_CMD_ERV_ALL 8'h01
`define NCLK_CMD_ERV_BLK 8'h02
`define NCLK_CMD_VER_SEC 8'h03
`define NCLK_CMD_RD_ONCE 8'h04
`define NCLK_CMD_PGM 8'h06
`define NCLK_CMD_PGM_ONCE 8'h07
`define NCLK_CMD_ERS_ALL 8'h08
`define NCLK_CMD_ERS_BLK 8'h09
`define NCLK_CMD_ERS_SEC 8'h0a
`define NCLK_CMD_UNSEC 8'h0b
`define NCLK_CMD_KEYVER 8'h0c
`define NCLK_CMD_MARGIN 8'h0d
`define NCLK_CMD_EE_VER 8'h10
`define NCLK_CMD_EE_PGM 8'h11
`define NCLK_CMD_EE_ERS 8'h12

// Timing
`define NCLK_CLK_HZ 20000000
`define NCLK_PE_HZ 1000000
`define NCLK_INIT_CYCLES 8'h10

`endif

// file: core/nclk_pe_div.v
// Purpose: Program/erase clock enable divider
// Assumes: Divide value from software, one enable pulse per divide_value+1 cycles
// Notes: Counts only while run is high
`timescale 1ns/10ps
module nclk_pe_div (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Control
    input wire i_run,
    input wire [5:0] i_divide_value,
    // Output
    output reg o_pe_tick
);

reg [5:0] cnt_r;

////////////////////////////////////////////////////////////////////////////////
// Divide bus clock by divide_value+1
always @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
        cnt_r <= 6'h00;
        o_pe_tick <= 1'b0;
    end else if (cnt_r >= i_divide_value) begin
        cnt_r <= 6'h00;
        o_pe_tick <= 1'b1;
    end else begin
        cnt_r <= cnt_r + 6'h01;
        o_pe_tick <= 1'b0;
    end
end

endmodule // nclk_pe_div

// file: core/nclk_front.v
// Purpose: NVM command front end: divider check, parameter array, launch/complete handshake
// Assumes: Memory controller completes via i_mc_done; ECC faults arrive as pulses
// Notes: 16-bit register port, parameter window 16 bits wide
// Functional notes
// - Divider write sets divider-loaded bit; reads zero until written.
// - Program/erase launch without loaded divider does not execute; access error set.
// - While command busy, parameter writes and new launches are ignored.
// - Parameter array reached through one window chosen by three-bit index.
// - Writing one to completion flag launches and transfers parameters.
// - Parameters locked during command; completion flag set at end.
// - Results written to array, valid once completion flag returns.
// - Indices six and seven ignore writes and read zero.
// - Word zero holds command and high address; others address and data.
// - Recognised codes 01-04, 06-0D, 10-12.
// - Secured state allows only 01,02,08,09,0B,0C,10; 0B only when secured.
// - Completion interrupt when flag set and local enable high.
// - Error interrupt when ECC fault flag and matching enable set.
// - Completion flag held low during init, set high at its end.
// - Stop request waits for active command to finish.
`timescale 1ns/10ps
`include "nclk_defs.vh"
module nclk_front #(
    parameter INIT_CYCLES = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Register port
    input wire [2:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // Memory controller side
    output reg o_mc_start,
    output reg [7:0] o_mc_cmd,
    output reg [23:0] o_mc_addr,
    output reg [63:0] o_mc_data,
    output wire o_pe_tick,
    input wire i_mc_done,
    input wire i_mc_prot_viol,
    input wire i_mc_res_we,
    input wire [2:0] i_mc_res_idx,
    input wire [15:0] i_mc_res_data,
    // Pin-level events and states
    input wire i_secured,
    input wire i_ecc_double,
    input wire i_ecc_single,
    input wire i_stop_req,
    // System outputs
    output wire o_stop_ack,
    output wire o_cmd_irq,
    output wire o_err_irq
);

// Sequencer states; the completion flag is simply the idle state
localparam ST_INIT = 2'h0;
localparam ST_IDLE = 2'h1;
localparam ST_BUSY = 2'h2;

// Sequencer and software-visible registers
reg [1:0] state_r;
reg [7:0] init_cnt_r;
reg [5:0] divide_value_r;
reg divider_loaded_r;
reg access_error_flag_r;
reg protection_violation_flag_r;
reg complete_irq_enable_r;
reg double_fault_flag_r;
reg single_fault_flag_r;
reg double_fault_irq_enable_r;
reg single_fault_irq_enable_r;
reg [2:0] parameter_index_r;
reg [15:0] param_r [0:`NCLK_PARAM_WORDS-1];
// Two-flop synchronisers for pin-level inputs and controller done
reg [1:0] sec_s_r;
reg [1:0] ecc_d_s_r;
reg [1:0] ecc_s_s_r;
reg [1:0] stop_s_r;
reg [1:0] done_s_r;

// Decode and launch qualifiers
wire command_complete_flag;
wire wr_clkdiv;
wire wr_status;
wire wr_param;
wire launch;
wire [7:0] command_code;
reg code_ok;
reg pe_cmd;

assign command_complete_flag = (state_r == ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for pin inputs and controller done
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        // Secured until the pin settles, so the wide code set stays shut
        sec_s_r <= 2'b11;
        ecc_d_s_r <= 2'b00;
        ecc_s_s_r <= 2'b00;
        stop_s_r <= 2'b00;
        done_s_r <= 2'b00;
    end else begin
        sec_s_r <= {sec_s_r[0], i_secured};
        ecc_d_s_r <= {ecc_d_s_r[0], i_ecc_double};
        ecc_s_s_r <= {ecc_s_s_r[0], i_ecc_single};
        stop_s_r <= {stop_s_r[0], i_stop_req};
        done_s_r <= {done_s_r[0], i_mc_done};
    end
end

// Write decode
assign wr_clkdiv = i_wr && (i_addr == `NCLK_OFF_CLKDIV);
assign wr_status = i_wr && (i_addr == `NCLK_OFF_STATUS);
// Index register is never locked; only the window itself is
// parameter lock
assign wr_param = i_wr && (i_addr == `NCLK_OFF_PARAM) && command_complete_flag;
assign launch = wr_status && i_wdata[`NCLK_ST_CCF_BIT] && command_complete_flag;
assign command_code = param_r[0][15:8];

////////////////////////////////////////////////////////////////////////////////
// Command code check against security state
always @* begin
    code_ok = 1'b0;
    pe_cmd = 1'b0;
    // Program/erase codes also need the divider, verify codes do not
    // code validity
    case (command_code)
        `NCLK_CMD_ERV_ALL, `NCLK_CMD_ERV_BLK, `NCLK_CMD_KEYVER,
        `NCLK_CMD_EE_VER: code_ok = 1'b1;
        `NCLK_CMD_ERS_ALL, `NCLK_CMD_ERS_BLK: begin
            code_ok = 1'b1;
            pe_cmd = 1'b1;
        end
        `NCLK_CMD_UNSEC: begin
            code_ok = sec_s_r[1];
            pe_cmd = 1'b1;
        end
        `NCLK_CMD_VER_SEC, `NCLK_CMD_RD_ONCE, `NCLK_CMD_MARGIN: code_ok = !sec_s_r[1];
        `NCLK_CMD_PGM, `NCLK_CMD_PGM_ONCE, `NCLK_CMD_ERS_SEC,
        `NCLK_CMD_EE_PGM, `NCLK_CMD_EE_ERS: begin
            code_ok = !sec_s_r[1];
            pe_cmd = 1'b1;
        end
        default: code_ok = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer: init, idle, busy
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        state_r <= ST_INIT;
        init_cnt_r <= 8'h00;
        o_mc_start <= 1'b0;
        o_mc_cmd <= 8'h00;
        o_mc_addr <= 24'h000000;
        o_mc_data <= 64'h0;
    end else begin
        o_mc_start <= 1'b0;
        case (state_r)
            ST_INIT: begin
                // Length is a parameter so benches can shorten start-up
                init_cnt_r <= init_cnt_r + 8'h01;
                if (init_cnt_r == INIT_CYCLES[7:0] - 8'h01) begin
                    state_r <= ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (launch && code_ok && (divider_loaded_r || !pe_cmd)) begin
                    state_r <= ST_BUSY;
                    o_mc_start <= 1'b1;
                    // Copied at launch, later window traffic cannot disturb the run
                    o_mc_cmd <= command_code;
                    o_mc_addr <= {param_r[0][7:0], param_r[1]};
                    o_mc_data <= {param_r[5], param_r[4], param_r[3], param_r[2]};
                end
            end
            ST_BUSY: begin
                // completion sets flag
                // Done is synchronised: two cycles later, but safe from any clock
                if (done_s_r[1]) begin
                    state_r <= ST_IDLE;
                end
            end
            default: state_r <= ST_INIT;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Divider register
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        divide_value_r <= `NCLK_DIV_RESET;
        divider_loaded_r <= 1'b0;
    end else if (wr_clkdiv) begin
        // Not range checked: too high a value overstresses the array
        divide_value_r <= i_wdata[5:0];
        divider_loaded_r <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Error flags: hardware set wins over write-one clear
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        access_error_flag_r <= 1'b0;
        protection_violation_flag_r <= 1'b0;
    end else begin
        if (launch && !(code_ok && (divider_loaded_r || !pe_cmd))) begin
            access_error_flag_r <= 1'b1;
        end else if (wr_status && i_wdata[`NCLK_ST_ACC_BIT]) begin
            access_error_flag_r <= 1'b0;
        end
        // Controller faults only count while a command runs
        if (state_r == ST_BUSY && i_mc_prot_viol) begin
            protection_violation_flag_r <= 1'b1;
        end else if (wr_status && i_wdata[`NCLK_ST_PV_BIT]) begin
            protection_violation_flag_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Config, index and ECC registers
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        complete_irq_enable_r <= 1'b0;
        parameter_index_r <= 3'h0;
        double_fault_irq_enable_r <= 1'b0;
        single_fault_irq_enable_r <= 1'b0;
        double_fault_flag_r <= 1'b0;
        single_fault_flag_r <= 1'b0;
    end else begin
        // Enables have no lock, software may change them mid-command
        if (i_wr && i_addr == `NCLK_OFF_CONFIG) begin
            complete_irq_enable_r <= i_wdata[`NCLK_CFG_COMPLETE_IRQ_ENABLE_BIT];
        end
        if (i_wr && i_addr == `NCLK_OFF_INDEX) begin
            parameter_index_r <= i_wdata[2:0];
        end
        if (i_wr && i_addr == `NCLK_OFF_ECCCFG) begin
            double_fault_irq_enable_r <= i_wdata[`NCLK_ECC_DF_BIT];
            single_fault_irq_enable_r <= i_wdata[`NCLK_ECC_SF_BIT];
        end
        // Fault flags: set wins over write-one clear
        if (ecc_d_s_r[1]) begin
            double_fault_flag_r <= 1'b1;
        end else if (i_wr && i_addr == `NCLK_OFF_ECCSTAT && i_wdata[`NCLK_ECC_DF_BIT]) begin
            double_fault_flag_r <= 1'b0;
        end
        if (ecc_s_s_r[1]) begin
            single_fault_flag_r <= 1'b1;
        end else if (i_wr && i_addr == `NCLK_OFF_ECCSTAT && i_wdata[`NCLK_ECC_SF_BIT]) begin
            single_fault_flag_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Parameter array, one generate slice per word
genvar gi;
generate
    for (gi = 0; gi < `NCLK_PARAM_WORDS; gi = gi + 1) begin : g_param
        always @(posedge i_clk) begin
            if (i_sys_rst) begin
                param_r[gi] <= 16'h0000;
            // Results land only while busy, so none leaks into the next set
            // results from controller
            end else if (state_r == ST_BUSY && i_mc_res_we && i_mc_res_idx == gi) begin
                param_r[gi] <= i_mc_res_data;
            // gated writes, six and seven dropped
            end else if (wr_param && parameter_index_r == gi) begin
                param_r[gi] <= i_wdata;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read mux, data one cycle after strobe
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_rdata <= 16'h0000;
    end else if (i_rd) begin
        // Non-read cycles return zero so a stray sample shows no stale data
        case (i_addr)
            `NCLK_OFF_CLKDIV: o_rdata <= {8'h00, divider_loaded_r, 1'b0, divide_value_r};
            `NCLK_OFF_STATUS: o_rdata <= {8'h00, command_complete_flag, 1'b0,
                access_error_flag_r, protection_violation_flag_r, 4'h0};
            `NCLK_OFF_INDEX: o_rdata <= {13'h0000, parameter_index_r};
            `NCLK_OFF_PARAM: o_rdata <= (parameter_index_r < 3'h6) ?
                param_r[parameter_index_r] : 16'h0000;
            `NCLK_OFF_CONFIG: o_rdata <= {8'h00, complete_irq_enable_r, 7'h00};
            `NCLK_OFF_ECCSTAT: o_rdata <= {14'h0000, double_fault_flag_r, single_fault_flag_r};
            `NCLK_OFF_ECCCFG: o_rdata <= {14'h0000, double_fault_irq_enable_r,
                single_fault_irq_enable_r};
            `NCLK_OFF_SECURE: o_rdata <= {15'h0000, sec_s_r[1]};
            default: o_rdata <= 16'h0000;
        endcase
    end else begin
        o_rdata <= 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt requests, global mask is the CPU's
// completion request
assign o_cmd_irq = command_complete_flag && complete_irq_enable_r;
assign o_err_irq = (double_fault_flag_r && double_fault_irq_enable_r) ||
    (single_fault_flag_r && single_fault_irq_enable_r);
// Limitation: acknowledge drops again as soon as a command launches
// stop waits for idle
assign o_stop_ack = stop_s_r[1] && (state_r != ST_BUSY);

// Program/erase clock enable only while busy
// Held clear while idle so every command starts with a full period
nclk_pe_div u_pe_div (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(state_r == ST_BUSY),
    .i_divide_value(divide_value_r),
    .o_pe_tick(o_pe_tick)
);

endmodule // nclk_front

// file: verification/nclk_front_props.sv
// Purpose: Port-level checks for the NVM command front end
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to nclk_front from the bench top file
`timescale 1ns/10ps
module nclk_front_props #(
    parameter INIT_CYCLES = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Register port
    input wire [2:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    // Controller and system outputs
    input wire o_mc_start,
    input wire [7:0] o_mc_cmd,
    input wire [23:0] o_mc_addr,
    input wire o_stop_ack,
    input wire o_cmd_irq,
    input wire o_err_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    reg [2:0] idx_r;
    reg cie_r;
    reg [1:0] eie_r;
    ////////////////////////////////////////////////////////////////
    // Shadow of index and enables, so irq checks need no body access
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            idx_r <= 3'h0;
            cie_r <= 1'b0;
            eie_r <= 2'h0;
        end else if (i_wr) begin
            if (i_addr == 3'h2) idx_r <= i_wdata[2:0];
            if (i_addr == 3'h4) cie_r <= i_wdata[7];
            if (i_addr == 3'h6) eie_r <= i_wdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence launch_s;
        i_wr && i_addr == 3'h1 && i_wdata[7];
    endsequence
    sequence quiet_s;
        !o_mc_start [*4];
    endsequence
    start_cause_a: assert property (o_mc_start |-> $past(i_wr) &&
        $past(i_addr) == 3'h1 && $past(i_wdata[7])) else $error("start without launch");
    no_relaunch_a: assert property (o_mc_start |=> quiet_s)
        else $error("second start too soon");
    busy_flag_a: assert property (o_mc_start |-> !o_cmd_irq)
        else $error("completion irq during start");
    stop_hold_a: assert property (o_mc_start |-> !o_stop_ack)
        else $error("stop ack while busy");
    mc_stable_a: assert property (!o_mc_start |-> $stable(o_mc_cmd) &&
        $stable(o_mc_addr)) else $error("controller outputs moved");
    idx_zero_a: assert property (i_rd && i_addr == 3'h3 && idx_r[2:1] == 2'b11
        |=> o_rdata == 16'h0000) else $error("unimplemented word not zero");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read cycle");
    cmd_irq_en_a: assert property (o_cmd_irq |-> cie_r)
        else $error("completion irq without enable");
    err_irq_en_a: assert property (o_err_irq |-> eie_r != 2'h0)
        else $error("error irq without enable");
    cover property (launch_s ##1 o_mc_start);
endmodule // nclk_front_props

// file: verification/nclk_mc_model.sv
// Purpose: Memory controller model on the far side of the front end
// Assumes: Start is a one-cycle pulse; latency at least 3
// Notes: Writes one result word, then pulses done once
`timescale 1ns/10ps
module nclk_mc_model (
    // Clock
    input wire i_clk,
    // Command side
    input wire i_start,
    input wire [7:0] i_cmd,
    input wire [7:0] i_lat,
    input wire i_pv,
    // Answer side
    output reg o_done,
    output reg o_pv,
    output reg o_we,
    output reg [2:0] o_idx,
    output reg [15:0] o_data
);
    integer cnt = -1;
    initial begin
        o_done = 1'b0;
        o_pv = 1'b0;
        o_we = 1'b0;
        o_idx = 3'h5;
        o_data = 16'h5555;
    end
    ////////////////////////////////////////////////////////////////
    // Result lines toggle when idle so stale values never look valid
    always @(posedge i_clk) begin
        o_we <= 1'b0;
        o_pv <= 1'b0;
        o_done <= 1'b0;
        o_idx <= ~o_idx;
        o_data <= ~o_data;
        if (i_start === 1'b1) cnt <= i_lat;
        else if (cnt >= 0) cnt <= cnt - 1;
        if (cnt == 3) begin
            o_we <= 1'b1;
            o_idx <= 3'h2;
            o_data <= {i_cmd, 8'h5a};
            o_pv <= i_pv;
        end
        if (cnt == 1) o_done <= 1'b1;
    end
endmodule // nclk_mc_model

// file: verification/nclk_front_bench.sv
// Purpose: Self-checking bench for the NVM command front end
// Assumes: 20 MHz clock, INIT_CYCLES set to 4
// Notes: Register model in reg arrays, compared at every read except status polling
`timescale 1ns/10ps
module nclk_front_bench;
    reg i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, pv_r = 0;
    reg i_secured = 1, i_ecc_double = 0, i_ecc_single = 0, i_stop_req = 0;
    reg [2:0] i_addr = 0;
    reg [15:0] i_wdata = 0, v;
    reg [15:0] arr [0:7];
    reg [31:0] w;
    reg [7:0] c;
    reg [7:0] codes [0:16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h05, 8'h0e};
    wire [15:0] o_rdata, res_data;
    wire [7:0] o_mc_cmd;
    wire [23:0] o_mc_addr;
    wire [63:0] o_mc_data;
    wire [2:0] res_idx;
    wire o_mc_start, o_pe_tick, done, pv, res_we, o_stop_ack, o_cmd_irq, o_err_irq;
    integer fails = 0, checks = 0, seed = 5044, nst = 0, n0, k, s, t, ok, b, npe = 0, p0;
    always #25 i_clk = ~i_clk;
    nclk_front #(.INIT_CYCLES(4)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_mc_start(o_mc_start), .o_mc_cmd(o_mc_cmd), .o_mc_addr(o_mc_addr),
        .o_mc_data(o_mc_data), .o_pe_tick(o_pe_tick), .i_mc_done(done),
        .i_mc_prot_viol(pv), .i_mc_res_we(res_we), .i_mc_res_idx(res_idx),
        .i_mc_res_data(res_data), .i_secured(i_secured), .i_ecc_double(i_ecc_double),
        .i_ecc_single(i_ecc_single), .i_stop_req(i_stop_req), .o_stop_ack(o_stop_ack),
        .o_cmd_irq(o_cmd_irq), .o_err_irq(o_err_irq));
    nclk_mc_model u_mc (.i_clk(i_clk), .i_start(o_mc_start), .i_cmd(o_mc_cmd),
        .i_lat(8'd20), .i_pv(pv_r), .o_done(done), .o_pv(pv), .o_we(res_we),
        .o_idx(res_idx), .o_data(res_data));
    // Launch counter
    always @(posedge i_clk) if (o_mc_start === 1'b1) nst <= nst + 1;
    // Program/erase tick counter
    always @(posedge i_clk) if (o_pe_tick === 1'b1) npe <= npe + 1;
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [63:0] e, input [63:0] g);
        checks = checks + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // One bus cycle, read data taken in the cycle after the strobe
    task acc(input wr, input [2:0] a, input [15:0] d);
        @(posedge i_clk);
        i_wr <= wr;
        i_rd <= !wr;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task rdc(input [2:0] a, input [15:0] m, input [15:0] e);
        acc(0, a, 16'h0);
        chk("register", e, v & m);
    endtask
    function integer ok_f(input [7:0] cd, input integer sc);
        case (cd)
            8'h01, 8'h02, 8'h08, 8'h09, 8'h0c, 8'h10: ok_f = 1;
            8'h0b: ok_f = sc;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h0a, 8'h0d, 8'h11, 8'h12: ok_f = !sc;
            default: ok_f = 0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 1400 cycles the run needs
    initial begin
        #2000000;
        fails = fails + 1;
        report_and_stop;
    end
    initial begin
        for (k = 0; k < 8; k++) arr[k] = 16'h0;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        i_stop_req <= 1'b1;
        rdc(3'h1, 16'h80, 16'h00);
        repeat (4) @(posedge i_clk);
        rdc(3'h1, 16'h80, 16'h80);
        rdc(3'h0, 16'h80, 16'h00);
        acc(1, 3'h2, 16'h0);
        acc(1, 3'h3, 16'h0800);
        acc(1, 3'h1, 16'h80);
        @(posedge i_clk);
        #1 chk("starts", 0, nst);
        rdc(3'h1, 16'hb0, 16'ha0);
        acc(1, 3'h1, 16'h00);
        rdc(3'h1, 16'hb0, 16'ha0);
        acc(1, 3'h1, 16'h20);
        rdc(3'h1, 16'hb0, 16'h80);
        acc(1, 3'h0, 16'h0013);
        rdc(3'h0, 16'hbf, 16'h93);
        acc(1, 3'h4, 16'h80);
        for (k = 0; k < 8; k++) begin
            acc(1, 3'h2, k);
            w = $random(seed);
            acc(1, 3'h3, w[15:0]);
            if (k < 6) arr[k] = w[15:0];
        end
        for (k = 0; k < 8; k++) begin
            acc(1, 3'h2, k);
            rdc(3'h3, 16'hffff, arr[k]);
        end
        for (s = 0; s < 2; s++) for (k = 0; k < 17; k++) begin
            c = codes[k];
            @(posedge i_clk);
            i_secured <= s[0];
            pv_r <= (c == 8'h11);
            repeat (3) @(posedge i_clk);
            rdc(3'h7, 16'h1, s);
            w = $random(seed);
            arr[0] = {c, w[7:0]};
            acc(1, 3'h2, 16'h0);
            acc(1, 3'h3, arr[0]);
            ok = ok_f(c, s);
            n0 = nst;
            p0 = npe;
            acc(1, 3'h1, 16'h80);
            if (ok) begin
                chk("irq busy", 0, o_cmd_irq);
                chk("stop busy", 0, o_stop_ack);
                acc(1, 3'h3, 16'hffff);
                acc(1, 3'h1, 16'h80);
                v = 16'h0;
                for (t = 0; t < 100 && v[7] !== 1'b1; t++) acc(0, 3'h1, 16'h0);
                chk("starts", n0 + 1, nst);
                chk("cmd", {c, arr[0][7:0], arr[1]}, {o_mc_cmd, o_mc_addr});
                chk("data", {arr[5], arr[4], arr[3], arr[2]}, o_mc_data);
                chk("irq done", 1, o_cmd_irq);
                chk("stop idle", 1, o_stop_ack);
                chk("pe ticks", p0 + 1, npe);
                arr[2] = {c, 8'h5a};
                rdc(3'h3, 16'hffff, arr[0]);
                acc(1, 3'h2, 16'h2);
                rdc(3'h3, 16'hffff, arr[2]);
            end else begin
                @(posedge i_clk);
                #1 chk("starts", n0, nst);
                chk("pe ticks", p0, npe);
            end
            rdc(3'h1, 16'hb0, {8'h0, 2'b10, ok == 0, c == 8'h11 && ok == 1, 4'h0});
            acc(1, 3'h1, 16'h30);
        end
        for (b = 0; b < 2; b++) begin
            acc(1, 3'h6, 16'h2 >> b);
            @(posedge i_clk);
            {i_ecc_double, i_ecc_single} <= 2'b01 << b;
            repeat (4) @(posedge i_clk);
            {i_ecc_double, i_ecc_single} <= 2'b00;
            repeat (3) @(posedge i_clk);
            rdc(3'h5, 16'h3, 16'h1 << b);
            chk("err masked", 0, o_err_irq);
            acc(1, 3'h6, 16'h1 << b);
            chk("err irq", 1, o_err_irq);
            acc(1, 3'h5, 16'h1 << b);
            rdc(3'h5, 16'h3, 16'h0);
            chk("err clear", 0, o_err_irq);
        end
        // Mid-run reset: init again, divider forgotten
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(3'h1, 16'h80, 16'h00);
        rdc(3'h0, 16'hbf, 16'h00);
        report_and_stop;
    end
endmodule // nclk_front_bench
bind nclk_front nclk_front_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mc_start(o_mc_start), .o_mc_cmd(o_mc_cmd), .o_mc_addr(o_mc_addr),
    .o_stop_ack(o_stop_ack), .o_cmd_irq(o_cmd_irq), .o_err_irq(o_err_irq));
